// ### verilog/tsc_top.sv
`timescale 1ns/1ps
`include "tsc_regs.svh"

module tsc_top import tsc_pkg::*; (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Processor status access.
  input wire logic ps_wr_en,
  input wire logic ps_rd_en,
  input wire logic [7:0] ps_addr,
  input wire logic [31:0] ps_wdata,
  output logic [31:0] ps_rdata,
  output logic ps_rvalid,
  // Event vector request.
  input wire logic evt_take,
  input wire logic [15:0] evt_vector,
  output logic [31:0] evt_target,
  output logic evt_target_valid,
  // Boot straps and status.
  input wire logic [7:0] proc_number,
  input wire logic strap_boot_ram,
  input wire logic strap_boot_jtag,
  input wire logic strap_no_poll,
  input wire logic [1:0] strap_pll_mode,
  // Security word from one-time memory.
  input wire logic otp_sec_valid,
  input wire logic [31:0] otp_sec_word,
  // Tile feature controls.
  output logic [1:0] ext_mem_size_sel,
  output logic ram_shutdown,
  output logic mem_auto_sleep_en,
  output logic camera_port_en,
  output logic pll_divider_en,
  output logic ext_mem_if_en,
  // Security controls.
  output logic global_debug_block,
  output logic jtag_tap_block,
  output logic otp_read_block,
  output logic otp_prog_block,
  output logic otp_single_space,
  output logic boot_from_otp,
  output logic pll_jtag_block,
  // Ring oscillators.
  output logic core_osc_run,
  output logic periph_osc_run,
  input wire logic [3:0] osc_in
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  tsc_state_t st_r;
  tsc_state_t st_nxt;
  logic [31:0] rd_word;
  logic [3:0] osc_on;
  logic [3:0] osc_start;

  // Oscillators 0 and 1 belong to the core pair, 2 and 3 to the peripheral pair.
  assign osc_on = {{2{st_r.osc_ctl[0]}}, {2{st_r.osc_ctl[1]}}}; // see RULE20

  // A pair that is switched on from off restarts its counters, so a count is known once its pair has first been started.
  assign osc_start = (ps_wr_en && ps_addr == `TSC_OSCILLATOR_CONTROL) ?
    ({{2{ps_wdata[0]}}, {2{ps_wdata[1]}}} & ~osc_on) : 4'h0; // see RULE19

  // Read multiplexer; unmapped numbers read zero.
  always_comb begin
    rd_word = 32'h00000000;
    unique case (ps_addr)
      `TSC_EVENT_VECTOR_HIGH: begin
        rd_word[`TSC_VEC_HI:`TSC_VEC_LO] = st_r.vbase; // see RULE1
      end
      `TSC_TILE_FEATURE_CONTROL: begin
        rd_word[`TSC_CTL_SIZE_HI:`TSC_CTL_SIZE_LO] = st_r.mem_size; // see RULE2
        rd_word[`TSC_CTL_RAM_OFF] = st_r.ram_off;
        rd_word[`TSC_CTL_SLEEP] = st_r.auto_sleep;
        rd_word[`TSC_CTL_CAMERA] = st_r.camera;
        rd_word[`TSC_CTL_DIVIDER] = st_r.divider;
        rd_word[`TSC_CTL_EXTMEM] = st_r.ext_mem; // see RULE7
      end
      `TSC_TILE_BOOT_STATUS: begin
        rd_word[23:16] = st_r.proc_num;
        rd_word[`TSC_BOOT_SECURE] = st_r.sec[`TSC_SEC_OTP_BOOT]; // see RULE9
        rd_word[`TSC_BOOT_NO_POLL] = st_r.no_poll; // see RULE9
        rd_word[`TSC_BOOT_RAM] = st_r.boot_ram; // see RULE8
        rd_word[`TSC_BOOT_JTAG] = st_r.boot_jtag; // see RULE8
        rd_word[1:0] = st_r.pll_pins; // see RULE8
      end
      `TSC_SECURITY_SETTINGS: begin
        rd_word = st_r.sec;
      end
      `TSC_OSCILLATOR_CONTROL: begin
        rd_word[1:0] = st_r.osc_ctl;
      end
      `TSC_CORE_CELL_OSC_COUNT: begin
        rd_word[15:0] = st_r.cnt[0]; // see RULE22
      end
      `TSC_CORE_WIRE_OSC_COUNT: begin
        rd_word[15:0] = st_r.cnt[1];
      end
      `TSC_PERIPH_CELL_OSC_COUNT: begin
        rd_word[15:0] = st_r.cnt[2];
      end
      `TSC_PERIPH_WIRE_OSC_COUNT: begin
        rd_word[15:0] = st_r.cnt[3];
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Next state: writes, strap capture, security load and counting.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = ps_rd_en;
    if (ps_rd_en) begin
      st_nxt.rdata = rd_word;
    end
    // Vector target: high half from base, low half from the resource.
    st_nxt.target_valid = evt_take;
    if (evt_take) begin
      st_nxt.target = {st_r.vbase, 3'h0, evt_vector}; // see RULE1
    end
    // Straps are caught once, on the first edge after reset release.
    if (!st_r.boot_done) begin
      st_nxt.boot_done = 1'b1;
      st_nxt.proc_num = proc_number;
      st_nxt.boot_ram = strap_boot_ram; // see RULE8
      st_nxt.boot_jtag = strap_boot_jtag;
      st_nxt.no_poll = strap_no_poll; // see RULE9
      st_nxt.pll_pins = strap_pll_mode;
    end
    if (ps_wr_en) begin
      unique case (ps_addr)
        `TSC_EVENT_VECTOR_HIGH: begin
          st_nxt.vbase = ps_wdata[`TSC_VEC_HI:`TSC_VEC_LO];
        end
        `TSC_TILE_FEATURE_CONTROL: begin
          st_nxt.mem_size = ps_wdata[`TSC_CTL_SIZE_HI:`TSC_CTL_SIZE_LO]; // see RULE2
          st_nxt.ram_off = ps_wdata[`TSC_CTL_RAM_OFF]; // see RULE3
          st_nxt.auto_sleep = ps_wdata[`TSC_CTL_SLEEP]; // see RULE4
          st_nxt.camera = ps_wdata[`TSC_CTL_CAMERA]; // see RULE5
          st_nxt.divider = ps_wdata[`TSC_CTL_DIVIDER]; // see RULE6
          st_nxt.ext_mem = ps_wdata[`TSC_CTL_EXTMEM]; // see RULE7
        end
        `TSC_SECURITY_SETTINGS: begin
          if (!st_r.sec[`TSC_SEC_WR_LOCK]) begin
            st_nxt.sec = ps_wdata & `TSC_SEC_MASK; // see RULE11 RULE23
          end
        end
        `TSC_OSCILLATOR_CONTROL: begin
          st_nxt.osc_ctl = ps_wdata[1:0]; // see RULE20
        end
        default: begin
          st_nxt.rvalid = ps_rd_en;
        end
      endcase
    end
    // The word from one-time memory wins over a processor write.
    if (otp_sec_valid) begin
      st_nxt.sec = otp_sec_word & `TSC_SEC_MASK; // see RULE10
    end
    // Each counter counts rising edges of its oscillator while it runs.
    st_nxt.osc_prev = osc_in;
    for (int i = 0; i < `TSC_OSC_N; i++) begin
      if (osc_on[i] && osc_in[i] && !st_r.osc_prev[i]) begin
        st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001; // see RULE19
      end
      if (osc_start[i]) begin
        st_nxt.cnt[i] = 16'h0000;
      end
    end
    // Reset clears control state, sets the memory size field to 3 and keeps the oscillator counts.
    if (!resetn) begin
      st_nxt = '0;
      st_nxt.cnt = st_r.cnt; // see RULE22
      st_nxt.mem_size = `TSC_SIZE_RST; // see RULE2
      st_nxt.sec = `TSC_SEC_RST;
    end
  end

  // Single state register.
  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Bus answer and vector target.
  assign ps_rdata = st_r.rdata;
  assign ps_rvalid = st_r.rvalid;
  assign evt_target = st_r.target;
  assign evt_target_valid = st_r.target_valid;

  // Tile feature controls straight from the control register.
  assign ext_mem_size_sel = st_r.mem_size;
  assign ram_shutdown = st_r.ram_off; // see RULE3
  assign mem_auto_sleep_en = st_r.auto_sleep; // see RULE4
  assign camera_port_en = st_r.camera; // see RULE5
  assign pll_divider_en = st_r.divider; // see RULE6
  assign ext_mem_if_en = st_r.ext_mem; // see RULE7

  // Security controls straight from the security register.
  assign global_debug_block = st_r.sec[`TSC_SEC_GLOBAL_DBG]; // see RULE12
  assign jtag_tap_block = st_r.sec[`TSC_SEC_TAP_OFF]; // see RULE13
  assign otp_read_block = st_r.sec[`TSC_SEC_OTP_RD_LOCK]; // see RULE14
  assign otp_prog_block = st_r.sec[`TSC_SEC_OTP_PROG_OFF]; // see RULE15
  assign otp_single_space = st_r.sec[`TSC_SEC_OTP_MERGE]; // see RULE16
  assign boot_from_otp = st_r.sec[`TSC_SEC_OTP_BOOT]; // see RULE17
  assign pll_jtag_block = st_r.sec[`TSC_SEC_PLL_JTAG]; // see RULE18

  // Oscillator enables.
  assign core_osc_run = st_r.osc_ctl[`TSC_OSC_CORE]; // see RULE20
  assign periph_osc_run = st_r.osc_ctl[`TSC_OSC_PERIPH]; // see RULE20

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // A read request followed by its answer one cycle later.
  sequence s_read(logic [7:0] num);
    resetn && ps_rd_en && ps_addr == num ##1 ps_rvalid;
  endsequence

  // A vector request followed by its target.
  sequence s_vec;
    resetn && evt_take ##1 evt_target_valid;
  endsequence

  property p_vec_addr;
    @(posedge mclk) disable iff (!resetn)
    s_vec |-> evt_target[15:0] == $past(evt_vector) && evt_target[18:16] == 3'h0
      && evt_target[31:19] == $past(st_r.vbase);
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector target mismatch"); // see RULE1

  property p_ctl_reset;
    @(posedge mclk)
    !resetn |=> ext_mem_size_sel == 2'h3 && !ram_shutdown && !mem_auto_sleep_en
      && !camera_port_en && !pll_divider_en && !ext_mem_if_en && !core_osc_run && !periph_osc_run;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control reset value wrong"); // see RULE2

  property p_ctl_write;
    @(posedge mclk) disable iff (!resetn)
    ps_wr_en && ps_addr == `TSC_TILE_FEATURE_CONTROL |=> ram_shutdown == $past(ps_wdata[10])
      && ext_mem_size_sel == $past(ps_wdata[12:11]) && pll_divider_en == $past(ps_wdata[4]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write not applied"); // see RULE3

  property p_ctl_read;
    @(posedge mclk) disable iff (!resetn)
    s_read(`TSC_TILE_FEATURE_CONTROL) |-> ps_rdata[31:13] == 19'h0 && ps_rdata[7:5] == 3'h0
      && ps_rdata[3:1] == 3'h0 && ps_rdata[0] == ext_mem_if_en && ps_rdata[9] == mem_auto_sleep_en;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read wrong"); // see RULE7

  property p_boot_read;
    @(posedge mclk) disable iff (!resetn)
    s_read(`TSC_TILE_BOOT_STATUS) |-> ps_rdata[8] == boot_from_otp && ps_rdata[31:24] == 8'h0
      && ps_rdata[3] == st_r.boot_ram && ps_rdata[1:0] == st_r.pll_pins;
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot status read wrong"); // see RULE8

  property p_sec_load;
    @(posedge mclk) disable iff (!resetn)
    otp_sec_valid |=> jtag_tap_block == $past(otp_sec_word[0])
      && otp_read_block == $past(otp_sec_word[9]) && global_debug_block == $past(otp_sec_word[14]);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security load wrong"); // see RULE10

  property p_sec_lock;
    @(posedge mclk) disable iff (!resetn)
    st_r.sec[31] && !otp_sec_valid && ps_wr_en && ps_addr == `TSC_SECURITY_SETTINGS |=> $stable(st_r.sec);
  endproperty
  a_sec_lock: assert property (p_sec_lock) else $error("locked security register changed"); // see RULE23

  property p_osc_stop;
    @(posedge mclk) disable iff (!resetn)
    !core_osc_run [*2] |-> $stable(st_r.cnt[0]) && $stable(st_r.cnt[1]);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("stopped counter moved"); // see RULE20

  property p_osc_count;
    @(posedge mclk) disable iff (!resetn)
    periph_osc_run && osc_in[2] && !st_r.osc_prev[2] |=> st_r.cnt[2] == $past(st_r.cnt[2]) + 16'h0001;
  endproperty
  a_osc_count: assert property (p_osc_count) else $error("counter missed an edge"); // see RULE19

  property p_osc_keep;
    @(posedge mclk)
    !resetn |=> $stable(st_r.cnt);
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("count lost across reset"); // see RULE22

endmodule

// ### verilog/tsc_regs.svh
// Functional notes
// RULE1 - Event target address takes high half from vector base, low half from vector.
// RULE2 - Control bits 12:11 select external memory size; field resets to 3.
// RULE3 - Control bit 10 shuts down on-chip RAMs; contents lost; resets to zero.
// RULE4 - Control bit 9 enables memory automatic sleep; resets to zero.
// RULE5 - Control bit 8 enables camera and display serial ports; resets to zero.
// RULE6 - Control bit 4 inserts clock divider after the PLL; resets to zero.
// RULE7 - Control bit 0 enables external memory interface; unused control bits read zero.
// RULE8 - Boot status shows RAM boot bit 3, JTAG boot bit 2, PLL straps 1:0.
// RULE9 - Boot status bit 4 skips read level polling; bit 8 shows secure boot override.
// RULE10 - Security register is loaded with the word read from one-time memory.
// RULE11 - Security bit 31 removes write permission from the security register.
// RULE12 - Security bit 14 blocks access to global debug.
// RULE13 - Security bit 0 blocks the processor JTAG debug port.
// RULE14 - Security bit 9 forbids reads of one-time memory.
// RULE15 - Security bit 8 blocks the one-time memory programming interface.
// RULE16 - Security bit 7 merges one-time memory into one read address space.
// RULE17 - Security bit 5 overrides boot mode and boots from one-time memory.
// RULE18 - Security bit 4 denies JTAG access to PLL and boot registers.
// RULE19 - Four free-running ring oscillators each drive a counter, started and stopped by control.
// RULE20 - Oscillator control bit 1 runs core oscillators, bit 0 peripheral ones; reset zero.
// RULE21 - Software reads a counter only after its oscillator stopped ten core cycles.
// RULE22 - Counters show 16 bits in 15:0, upper bits zero, kept across reset.
// RULE23 - Writes to a write-locked security register are ignored silently.
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define TSC_EVENT_VECTOR_HIGH 8'h01
`define TSC_TILE_FEATURE_CONTROL 8'h02
`define TSC_TILE_BOOT_STATUS 8'h03
`define TSC_SECURITY_SETTINGS 8'h05
`define TSC_OSCILLATOR_CONTROL 8'h06
`define TSC_CORE_CELL_OSC_COUNT 8'h07
`define TSC_CORE_WIRE_OSC_COUNT 8'h08
`define TSC_PERIPH_CELL_OSC_COUNT 8'h09
`define TSC_PERIPH_WIRE_OSC_COUNT 8'h0A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSC_VEC_HI 31
`define TSC_VEC_LO 19
`define TSC_CTL_SIZE_HI 12
`define TSC_CTL_SIZE_LO 11
`define TSC_CTL_RAM_OFF 10
`define TSC_CTL_SLEEP 9
`define TSC_CTL_CAMERA 8
`define TSC_CTL_DIVIDER 4
`define TSC_CTL_EXTMEM 0
`define TSC_BOOT_SECURE 8
`define TSC_BOOT_NO_POLL 4
`define TSC_BOOT_RAM 3
`define TSC_BOOT_JTAG 2
`define TSC_SEC_WR_LOCK 31
`define TSC_SEC_GLOBAL_DBG 14
`define TSC_SEC_OTP_RD_LOCK 9
`define TSC_SEC_OTP_PROG_OFF 8
`define TSC_SEC_OTP_MERGE 7
`define TSC_SEC_OTP_BOOT 5
`define TSC_SEC_PLL_JTAG 4
`define TSC_SEC_TAP_OFF 0
`define TSC_OSC_CORE 1
`define TSC_OSC_PERIPH 0

// ----------------------------------------
// Reset values, masks and sizes
// ----------------------------------------
`define TSC_SIZE_RST 2'h3
`define TSC_SEC_RST 32'h00000000
`define TSC_SEC_MASK 32'h800043B1
`define TSC_CNT_W 16
`define TSC_OSC_N 4

`endif

// ### verilog/tsc_pkg.sv
package tsc_pkg;

  // Complete state of the register group.
  typedef struct packed {
    logic [12:0] vbase;
    logic [1:0] mem_size;
    logic ram_off;
    logic auto_sleep;
    logic camera;
    logic divider;
    logic ext_mem;
    logic [31:0] sec;
    logic [1:0] osc_ctl;
    logic boot_done;
    logic [7:0] proc_num;
    logic boot_ram;
    logic boot_jtag;
    logic no_poll;
    logic [1:0] pll_pins;
    logic [3:0] osc_prev;
    logic [3:0][15:0] cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] target;
    logic target_valid;
  } tsc_state_t;

endpackage

// ### verif/tsc_tb.sv
`timescale 1ns/1ps
`include "tsc_regs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module testbench import tsc_pkg::*;;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  typedef struct {logic [31:0] ex; logic [31:0] mk; string nm;} tsc_note_t;
  logic mclk, resetn, ps_wr_en, ps_rd_en, evt_take, evt_target_valid, ps_rvalid;
  logic [7:0] ps_addr, proc_number;
  logic [31:0] ps_wdata, ps_rdata, evt_target, otp_sec_word, v, w;
  logic [15:0] evt_vector;
  logic strap_boot_ram, strap_boot_jtag, strap_no_poll, otp_sec_valid;
  logic [1:0] strap_pll_mode, ext_mem_size_sel;
  logic ram_shutdown, mem_auto_sleep_en, camera_port_en, pll_divider_en, ext_mem_if_en;
  logic global_debug_block, jtag_tap_block, otp_read_block, otp_prog_block;
  logic otp_single_space, boot_from_otp, pll_jtag_block, core_osc_run, periph_osc_run;
  logic [3:0] osc_in;
  logic [3:0][15:0] exp_cnt;
  tsc_note_t rd_q[$];
  tsc_note_t n;
  logic [31:0] evt_q[$];
  logic [31:0] e;
  int miscompares = 0;
  int cmp_count = 0;

  tsc_top dut_u (.mclk(mclk), .resetn(resetn), .ps_wr_en(ps_wr_en), .ps_rd_en(ps_rd_en),
    .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid),
    .evt_take(evt_take), .evt_vector(evt_vector), .evt_target(evt_target),
    .evt_target_valid(evt_target_valid), .proc_number(proc_number), .strap_boot_ram(strap_boot_ram),
    .strap_boot_jtag(strap_boot_jtag), .strap_no_poll(strap_no_poll), .strap_pll_mode(strap_pll_mode),
    .otp_sec_valid(otp_sec_valid), .otp_sec_word(otp_sec_word), .ext_mem_size_sel(ext_mem_size_sel),
    .ram_shutdown(ram_shutdown), .mem_auto_sleep_en(mem_auto_sleep_en), .camera_port_en(camera_port_en),
    .pll_divider_en(pll_divider_en), .ext_mem_if_en(ext_mem_if_en), .global_debug_block(global_debug_block),
    .jtag_tap_block(jtag_tap_block), .otp_read_block(otp_read_block), .otp_prog_block(otp_prog_block),
    .otp_single_space(otp_single_space), .boot_from_otp(boot_from_otp), .pll_jtag_block(pll_jtag_block),
    .core_osc_run(core_osc_run), .periph_osc_run(periph_osc_run), .osc_in(osc_in));

  // 40 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Drivers, all called at a falling edge
  // ----------------------------------------
  task automatic idle(input int c);
    ps_wr_en = 1'b0;
    ps_rd_en = 1'b0;
    evt_take = 1'b0;
    otp_sec_valid = 1'b0;
    repeat (c) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ps_wr_en = 1'b1;
    ps_rd_en = 1'b0;
    evt_take = 1'b0;
    otp_sec_valid = 1'b0;
    ps_addr = a;
    ps_wdata = d;
    @(negedge mclk);
  endtask

  // Issues a read and notes the expected answer, masked to the bits that are judged.
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk, input string nm);
    ps_rd_en = 1'b1;
    ps_wr_en = 1'b0;
    evt_take = 1'b0;
    otp_sec_valid = 1'b0;
    ps_addr = a;
    rd_q.push_back('{ex & mk, mk, nm});
    @(negedge mclk);
  endtask

  task automatic otp(input logic [31:0] d);
    otp_sec_valid = 1'b1;
    ps_wr_en = 1'b0;
    ps_rd_en = 1'b0;
    evt_take = 1'b0;
    otp_sec_word = d;
    @(negedge mclk);
  endtask

  task automatic evt(input logic [31:0] base, input logic [15:0] vec);
    evt_take = 1'b1;
    ps_wr_en = 1'b0;
    ps_rd_en = 1'b0;
    otp_sec_valid = 1'b0;
    evt_vector = vec;
    evt_q.push_back({base[31:19], 3'h0, vec});
    @(negedge mclk);
  endtask

  // Boot status as the straps and the secure boot bit should show it.
  function automatic logic [31:0] boot_exp(input logic s5);
    return {8'h00, proc_number, 7'h00, s5, 3'h0, strap_no_poll, strap_boot_ram, strap_boot_jtag, strap_pll_mode};
  endfunction

  task automatic summarize();
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitors take the oldest note per answer
  // ----------------------------------------
  always @(negedge mclk) begin
    if (ps_rvalid === 1'b1) begin
      n = (rd_q.size() > 0) ? rd_q.pop_front() : tsc_note_t'{32'hFFFFFFFF, 32'h0, "unexpected read"};
      `CHK(n.nm, n.ex, ps_rdata & n.mk)
    end
    if (evt_target_valid === 1'b1) begin
      e = (evt_q.size() > 0) ? evt_q.pop_front() : 32'hXXXXXXXX;
      `CHK("evt_target", e, evt_target)
    end
  end

  // Watchdog well beyond the length of all tests.
  initial begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    v = $urandom(32'h0EC71064);
    {ps_addr, ps_wdata, evt_vector, osc_in, otp_sec_word} = '0;
    {proc_number, strap_boot_ram, strap_boot_jtag, strap_no_poll, strap_pll_mode} = 13'($urandom);
    resetn = 1'b0;
    idle(16);
    resetn = 1'b1;
    idle(2);
    `CHK("size_sel", 2'h3, ext_mem_size_sel)
    `CHK("ctl_levels", 5'h00, {ram_shutdown, mem_auto_sleep_en, camera_port_en, pll_divider_en, ext_mem_if_en})
    `CHK("osc_run", 2'h0, {core_osc_run, periph_osc_run})
    rd(`TSC_TILE_FEATURE_CONTROL, 32'h00001800, '1, "ctl_reset");
    rd(`TSC_OSCILLATOR_CONTROL, 32'h0, '1, "osc_reset");
    rd(`TSC_SECURITY_SETTINGS, 32'h0, '1, "sec_reset");
    rd(`TSC_TILE_BOOT_STATUS, boot_exp(1'b0), '1, "boot");
    rd(8'h04, 32'h0, '1, "unmapped");
    idle(2);
    $display("test reset_values done");
    // Vector base keeps only 31:19; events back to back.
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : $urandom;
      wr(`TSC_EVENT_VECTOR_HIGH, v);
      rd(`TSC_EVENT_VECTOR_HIGH, v & 32'hFFF80000, '1, "vector");
      evt(v, 16'($urandom));
      evt(v, 16'hFFFF);
    end
    idle(2);
    $display("test event_vector done");
    // Tile control fields, outputs and reserved bits.
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom;
      wr(`TSC_TILE_FEATURE_CONTROL, v);
      `CHK("size_sel", v[12:11], ext_mem_size_sel)
      `CHK("ram_off", v[10], ram_shutdown)
      `CHK("sleep", v[9], mem_auto_sleep_en)
      `CHK("camera", v[8], camera_port_en)
      `CHK("divider", v[4], pll_divider_en)
      `CHK("ext_mem", v[0], ext_mem_if_en)
      rd(`TSC_TILE_FEATURE_CONTROL, v & 32'h00001F11, '1, "ctl");
    end
    wr(`TSC_TILE_BOOT_STATUS, 32'hFFFFFFFF);
    rd(`TSC_TILE_BOOT_STATUS, boot_exp(1'b0), '1, "boot_ro");
    idle(2);
    $display("test tile_control done");
    // Security word from one-time memory, processor writes and the lock.
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 32'h000043B1 : $urandom & 32'h000043B1;
      otp(w);
      idle(1);
      `CHK("sec_outs", {w[14], w[0], w[9], w[8], w[7], w[5], w[4]}, {global_debug_block, jtag_tap_block,
        otp_read_block, otp_prog_block, otp_single_space, boot_from_otp, pll_jtag_block})
      rd(`TSC_SECURITY_SETTINGS, w, '1, "sec_otp");
      rd(`TSC_TILE_BOOT_STATUS, boot_exp(w[5]), '1, "boot_secure");
      v = $urandom & 32'h7FFFFFFF;
      wr(`TSC_SECURITY_SETTINGS, v);
      rd(`TSC_SECURITY_SETTINGS, v & 32'h800043B1, '1, "sec_wr");
    end
    wr(`TSC_SECURITY_SETTINGS, 32'h80000210);
    wr(`TSC_SECURITY_SETTINGS, 32'h00004021);
    rd(`TSC_SECURITY_SETTINGS, 32'h80000210, '1, "sec_locked");
    idle(1);
    `CHK("locked_outs", 4'h9, {otp_read_block, boot_from_otp, jtag_tap_block, pll_jtag_block})
    idle(2);
    $display("test security done");
    // Oscillators run, stop, settle and are read.
    for (int i = 0; i < 4; i++) begin
      wr(`TSC_OSCILLATOR_CONTROL, 32'(i) | 32'hFFFFFFFC);
      `CHK("osc_run", 2'(i), {core_osc_run, periph_osc_run})
      rd(`TSC_OSCILLATOR_CONTROL, 32'(i), '1, "osc_ctl");
      // A pair switched on from off starts counting from zero.
      if (i == 1 || i == 3) begin
        exp_cnt[2] = 16'h0000;
        exp_cnt[3] = 16'h0000;
      end
      if (i == 2) begin
        exp_cnt[0] = 16'h0000;
        exp_cnt[1] = 16'h0000;
      end
      for (int k = 0; k < 12; k++) begin
        w = $urandom;
        for (int b = 0; b < 4; b++) begin
          if (i[(b < 2) ? 1 : 0] && w[b] && !osc_in[b]) begin
            exp_cnt[b] = exp_cnt[b] + 16'h0001;
          end
        end
        osc_in = w[3:0];
        idle(1);
      end
    end
    wr(`TSC_OSCILLATOR_CONTROL, 32'h0);
    idle(10);
    for (int a = 7; a <= 10; a++) begin
      rd(8'(a), {16'h0000, exp_cnt[a - 7]}, '1, "osc_count");
    end
    idle(2);
    $display("test oscillators done");
    // Second reset mid-run restores control and security values.
    wr(`TSC_TILE_FEATURE_CONTROL, 32'h00000711);
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    idle(2);
    rd(`TSC_TILE_FEATURE_CONTROL, 32'h00001800, '1, "ctl_rereset");
    rd(`TSC_SECURITY_SETTINGS, 32'h0, '1, "sec_rereset");
    rd(`TSC_CORE_CELL_OSC_COUNT, {16'h0000, exp_cnt[0]}, '1, "osc_kept");
    idle(4);
    `CHK("notes_left", 0, rd_q.size() + evt_q.size())
    $display("test second_reset done");
    summarize();
  end
endmodule
